//--- src/lock_pkg.sv
/*
 * shared constants and types for the serial flash block lock logic: opcodes, bit counts,
 * block geometry, one-time-programmable store layout, state and carrier structs.
 * assumes a serial link in mode 0 or 3 and a 2 MB array split into 4 kB lock blocks.
 */
package lock_pkg;
	// ----------------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
	localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;
	localparam logic [7:0] OP_READ_LOCK_A = 8'h3C;
	localparam logic [7:0] OP_READ_LOCK_B = 8'h3D;
	localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
	localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
	// ----------------------------------------------------------------------
	// frame bit counts
	// ----------------------------------------------------------------------
	localparam logic [5:0] OPCODE_BITS = 6'h08;
	localparam logic [5:0] CMD_ADDR_BITS = 6'h20;
	localparam logic [5:0] IDX_READY_BITS = 6'h14;
	localparam logic [5:0] REPEAT_LAST_BIT = 6'h27;
	localparam logic [2:0] LAST_BIT_OF_BYTE = 3'h7;
	// ----------------------------------------------------------------------
	// array geometry and protection decode
	// ----------------------------------------------------------------------
	localparam int BLK_LSB = 12;
	localparam int BLK_W = 9;
	localparam int NUM_BLK = 512;
	localparam int ARRAY_AW = 21;
	localparam int SEC_UNIT_LSB = 12;
	localparam int BP_UNIT_LSB = 16;
	localparam logic LOCK_RESET = 1'b1;
	// ----------------------------------------------------------------------
	// one-time-programmable store
	// ----------------------------------------------------------------------
	localparam int OTP_BYTES = 512;
	localparam int OTP_AW = 9;
	localparam logic [8:0] OTP_FACTORY_LAST = 9'h07F;
	localparam logic [7:0] OTP_ERASED = 8'hFF;

	typedef struct packed {
		logic frame_tog;
		logic req_tog;
		logic [7:0] opcode;
		logic [5:0] bits;
		logic [BLK_W-1:0] blk_idx;
		logic [BLK_W-1:0] rd_idx;
	} link_report_t;

	typedef struct packed {
		logic protection_scheme_select;
		logic protect_complement;
		logic protect_granule_select;
		logic top_bottom_select;
		logic [2:0] block_protect_bits;
	} prot_cfg_t;

	typedef struct packed {
		logic frame_tog;
		logic req_tog;
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [5:0] bits;
		logic [BLK_W-1:0] rd_idx;
		logic [1:0] lock_sync;
	} link_state_t;

	typedef struct packed {
		logic [2:0] cs_sync;
		logic [1:0] frame_sync;
		logic frame_seen;
		logic [1:0] req_sync;
		logic req_seen;
		logic [NUM_BLK-1:0] lock;
		logic write_enable_latch;
		logic lock_bit;
		logic prot_locked;
	} core_state_t;

	typedef struct packed {
		logic [OTP_BYTES-1:0][7:0] mem;
		logic [7:0] rdata;
	} otp_state_t;

	localparam link_state_t LINK_RESET = '0;
	localparam core_state_t CORE_RESET = '{cs_sync: 3'h7, frame_sync: 2'h0, frame_seen: 1'b0,
		req_sync: 2'h0, req_seen: 1'b0, lock: {NUM_BLK{LOCK_RESET}}, write_enable_latch: 1'b0,
		lock_bit: LOCK_RESET, prot_locked: 1'b1};

	function automatic logic is_readback(input logic [7:0] op);
		return (op == OP_READ_LOCK_A) || (op == OP_READ_LOCK_B);
	endfunction
endpackage

//--- src/lock_link_shifter.sv
/*
 * link side of the block lock logic, clocked by the serial clock: shifts in opcode and
 * address, posts frame and readback events by toggles, drives the lock byte out.
 * assumes the serial clock only runs while chip select is low; chip select high sets
 * the frame start flag and clears the output stage.
 */
`timescale 1ns/1ps
module lock_link_shifter (
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic rst_i,
	input wire logic mosi_i,
	input wire logic lock_bit_i,
	output lock_pkg::link_report_t report_o,
	output logic so_o,
	output logic so_oe_o
);
	lock_pkg::link_state_t q, n;
	logic frame_rst;
	logic armed_q;
	logic drive;
	logic [5:0] base;

	assign frame_rst = rst_i | cs_n_i;

	// ----------------------------------------------------------------------
	// input shifting, msb first
	// ----------------------------------------------------------------------
	always_comb begin
		n = q;
		base = armed_q ? 6'h00 : q.bits;
		n.lock_sync = {q.lock_sync[0], lock_bit_i};
		if (armed_q) begin
			n.frame_tog = ~q.frame_tog;
		end
		if (base < lock_pkg::OPCODE_BITS) begin
			n.opcode = {q.opcode[6:0], mosi_i};
		end else if (base < lock_pkg::CMD_ADDR_BITS) begin
			n.addr = {q.addr[22:0], mosi_i};
		end
		// count wraps inside the data byte so the returned byte repeats
		n.bits = (base == lock_pkg::REPEAT_LAST_BIT) ? lock_pkg::CMD_ADDR_BITS : base + 6'h01;
		// block index is known once A12 is in, well before the data byte
		if (n.bits == lock_pkg::IDX_READY_BITS && lock_pkg::is_readback(q.opcode)) begin
			n.rd_idx = n.addr[lock_pkg::BLK_W-1:0];
			n.req_tog = ~q.req_tog;
		end
	end

	assign report_o = '{frame_tog: q.frame_tog, req_tog: q.req_tog, opcode: q.opcode,
		bits: q.bits, blk_idx: q.addr[lock_pkg::BLK_LSB+lock_pkg::BLK_W-1:lock_pkg::BLK_LSB],
		rd_idx: q.rd_idx};

	// state register on the serial clock
	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= lock_pkg::LINK_RESET;
		end else begin
			q <= n;
		end
	end

	// set while chip select is high, cleared by the first clock of a frame
	always_ff @(posedge sclk_i or posedge frame_rst) begin
		if (frame_rst) begin
			armed_q <= 1'b1;
		end else begin
			armed_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// output byte on the falling edge: bits 7:1 zero, bit 0 the lock state
	// ----------------------------------------------------------------------
	assign drive = !armed_q && (q.bits >= lock_pkg::CMD_ADDR_BITS) && lock_pkg::is_readback(q.opcode);

	always_ff @(negedge sclk_i or posedge frame_rst) begin
		if (frame_rst) begin
			so_o <= 1'b0;
			so_oe_o <= 1'b0;
		end else begin
			so_o <= drive && (q.bits[2:0] == lock_pkg::LAST_BIT_OF_BYTE) && q.lock_sync[1];
			so_oe_o <= drive;
		end
	end
endmodule

//--- src/otp_store.sv
/*
 * one-time-programmable security store: four 128-byte registers kept apart from the main
 * array; the first is factory content and never written.
 * assumes the caller gates programming with the write-enable latch.
 */
`timescale 1ns/1ps
module otp_store (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [8:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic prog_i,
	output logic [7:0] rdata_o
);
	lock_pkg::otp_state_t q, n;

	// programming only clears bits, and never reaches the factory register
	always_comb begin
		n = q;
		n.rdata = q.mem[addr_i];
		if (prog_i && addr_i > lock_pkg::OTP_FACTORY_LAST) begin
			n.mem[addr_i] = q.mem[addr_i] & wdata_i;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '{mem: {lock_pkg::OTP_BYTES{lock_pkg::OTP_ERASED}}, rdata: 8'h00};
		end else begin
			q <= n;
		end
	end

	assign rdata_o = q.rdata;
endmodule

//--- src/spi_flash_block_lock_control.sv
/*
 * per-block write protection of a serial flash: lock array, write-enable latch, command
 * execution at chip select rise, lock readback lookup, protection decode, security store.
 * assumes the serial link runs on its own clock and stops outside frames; chip select is
 * held high for several system clocks between frames.
 */
`timescale 1ns/1ps
module spi_flash_block_lock_control (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic so_o,
	output logic so_oe_o,
	input lock_pkg::prot_cfg_t prot_cfg_i,
	input wire logic [23:0] prot_addr_i,
	output logic prot_locked_o,
	output logic write_enable_latch_o,
	input wire logic [8:0] otp_addr_i,
	input wire logic [7:0] otp_wdata_i,
	input wire logic otp_prog_i,
	output logic [7:0] otp_rdata_o
);
	lock_pkg::core_state_t q, n;
	lock_pkg::link_report_t rep;
	logic cs_rise;
	logic new_frame;
	logic exec;
	logic aligned;
	logic addr_full;
	logic lock_op;
	logic req_new;
	logic otp_prog;
	logic sel_lock;
	logic prot_blk_lock;
	logic legacy_hit;
	logic [lock_pkg::ARRAY_AW-1:0] prot_a;
	int span;

	// ----------------------------------------------------------------------
	// link side, on the serial clock
	// ----------------------------------------------------------------------
	lock_link_shifter link (
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.rst_i(rst_i),
		.mosi_i(mosi_i),
		.lock_bit_i(q.lock_bit),
		.report_o(rep),
		.so_o(so_o),
		.so_oe_o(so_oe_o)
	);

	// ----------------------------------------------------------------------
	// security store, separate from the lock array
	// ----------------------------------------------------------------------
	assign otp_prog = otp_prog_i && q.write_enable_latch;

	otp_store otp (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.addr_i(otp_addr_i),
		.wdata_i(otp_wdata_i),
		.prog_i(otp_prog),
		.rdata_o(otp_rdata_o)
	);

	// ----------------------------------------------------------------------
	// frame end decode
	// ----------------------------------------------------------------------
	// link report is static once the serial clock stops, so it is read at chip select rise
	assign cs_rise = q.cs_sync[1] & ~q.cs_sync[2];
	assign new_frame = q.frame_sync[1] != q.frame_seen;
	assign exec = cs_rise && new_frame;
	assign aligned = rep.bits[2:0] == 3'h0;
	assign addr_full = rep.bits >= lock_pkg::CMD_ADDR_BITS;
	assign lock_op = (rep.opcode == lock_pkg::OP_BLOCK_LOCK) ||
		(rep.opcode == lock_pkg::OP_BLOCK_UNLOCK) ||
		(rep.opcode == lock_pkg::OP_GLOBAL_LOCK) ||
		(rep.opcode == lock_pkg::OP_GLOBAL_UNLOCK);
	assign req_new = q.req_sync[1] != q.req_seen;
	assign sel_lock = q.lock[rep.rd_idx];

	// ----------------------------------------------------------------------
	// protection decode for the queried address
	// ----------------------------------------------------------------------
	assign prot_a = prot_addr_i[lock_pkg::ARRAY_AW-1:0];
	assign prot_blk_lock = q.lock[prot_addr_i[lock_pkg::BLK_LSB+lock_pkg::BLK_W-1:lock_pkg::BLK_LSB]];

	// legacy window: size doubles per protect step, anchored at bottom or top
	always_comb begin
		span = (prot_cfg_i.protect_granule_select ? lock_pkg::SEC_UNIT_LSB : lock_pkg::BP_UNIT_LSB)
			+ int'(prot_cfg_i.block_protect_bits) - 1;
		if (prot_cfg_i.block_protect_bits == 3'h0) begin
			legacy_hit = 1'b0;
		end else if (prot_cfg_i.top_bottom_select) begin
			legacy_hit = (prot_a >> span) == '0;
		end else begin
			legacy_hit = ((~prot_a) >> span) == '0;
		end
	end

	// ----------------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------------
	always_comb begin
		n = q;
		n.cs_sync = {q.cs_sync[1:0], cs_n_i};
		n.frame_sync = {q.frame_sync[0], rep.frame_tog};
		n.req_sync = {q.req_sync[0], rep.req_tog};
		// security store program clears the latch; a write enable ending in the same cycle wins
		if (otp_prog) begin
			n.write_enable_latch = 1'b0;
		end
		// commands take effect only when the frame ends
		if (exec) begin
			n.frame_seen = q.frame_sync[1];
			if (aligned) begin
				unique case (rep.opcode)
					lock_pkg::OP_WRITE_ENABLE: n.write_enable_latch = 1'b1;
					lock_pkg::OP_WRITE_DISABLE: n.write_enable_latch = 1'b0;
					lock_pkg::OP_BLOCK_LOCK,
					lock_pkg::OP_BLOCK_UNLOCK: begin
						if (addr_full && q.write_enable_latch) begin
							n.lock[rep.blk_idx] = rep.opcode == lock_pkg::OP_BLOCK_LOCK;
							n.write_enable_latch = 1'b0;
						end
					end
					lock_pkg::OP_GLOBAL_LOCK: begin
						if (q.write_enable_latch) begin
							n.lock = {lock_pkg::NUM_BLK{1'b1}};
							n.write_enable_latch = 1'b0;
						end
					end
					lock_pkg::OP_GLOBAL_UNLOCK: begin
						if (q.write_enable_latch) begin
							n.lock = '0;
							n.write_enable_latch = 1'b0;
						end
					end
					default: begin
					end
				endcase
			end
		end
		// readback lookup, answered as a level toward the link side
		if (req_new) begin
			n.req_seen = q.req_sync[1];
			n.lock_bit = sel_lock;
		end
		n.prot_locked = prot_cfg_i.protection_scheme_select ? prot_blk_lock :
			(legacy_hit ^ prot_cfg_i.protect_complement);
	end

	// state register; reset leaves the whole array locked
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			q <= lock_pkg::CORE_RESET;
		end else begin
			q <= n;
		end
	end

	assign prot_locked_o = q.prot_locked;
	assign write_enable_latch_o = q.write_enable_latch;

	// ----------------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	a_wel_set_enable: assert property (
		exec && aligned && rep.opcode == lock_pkg::OP_WRITE_ENABLE |=> q.write_enable_latch && write_enable_latch_o)
		else $error("write enable did not set latch");

	a_global_lock_all: assert property (
		exec && aligned && q.write_enable_latch && rep.opcode == lock_pkg::OP_GLOBAL_LOCK |=> &q.lock)
		else $error("global lock left a block unlocked");

	a_global_unlock_all: assert property (
		exec && aligned && q.write_enable_latch && rep.opcode == lock_pkg::OP_GLOBAL_UNLOCK |=> q.lock == '0)
		else $error("global unlock left a block locked");

	a_block_unlock_one: assert property (
		exec && aligned && addr_full && q.write_enable_latch && rep.opcode == lock_pkg::OP_BLOCK_UNLOCK
		|=> !q.lock[rep.blk_idx] && $countones(q.lock ^ $past(q.lock)) <= 1)
		else $error("single unlock wrong");

	a_block_lock_one: assert property (
		exec && aligned && addr_full && q.write_enable_latch && rep.opcode == lock_pkg::OP_BLOCK_LOCK
		|=> q.lock[rep.blk_idx])
		else $error("single lock wrong");

	a_wel_clear_after: assert property (
		exec && aligned && q.write_enable_latch && lock_op && (addr_full ||
		rep.opcode == lock_pkg::OP_GLOBAL_LOCK || rep.opcode == lock_pkg::OP_GLOBAL_UNLOCK)
		|=> !q.write_enable_latch)
		else $error("latch not cleared after lock change");

	a_no_wel_hold: assert property (
		exec && lock_op && !q.write_enable_latch |=> $stable(q.lock))
		else $error("lock changed without latch");

	a_misalign_hold: assert property (
		exec && !aligned |=> $stable(q.lock) ##0 $stable(q.write_enable_latch))
		else $error("misaligned frame changed state");

	a_readback_lookup: assert property (
		req_new |=> q.lock_bit == $past(sel_lock))
		else $error("readback bit not from addressed block");

	a_scheme_select: assert property (
		prot_cfg_i.protection_scheme_select ##1 prot_cfg_i.protection_scheme_select
		|-> prot_locked_o == $past(prot_blk_lock))
		else $error("protection not from block lock");

	a_idle_no_change: assert property (
		!exec && !otp_prog |=> $stable(q.lock) && $stable(q.write_enable_latch))
		else $error("state changed outside frame end");

	c_global_unlock: cover property (
		exec && aligned && q.write_enable_latch && rep.opcode == lock_pkg::OP_GLOBAL_UNLOCK);
	c_block_unlock: cover property (
		exec && aligned && addr_full && q.write_enable_latch && rep.opcode == lock_pkg::OP_BLOCK_UNLOCK);
	c_readback: cover property (req_new ##1 !q.lock_bit);
	c_misaligned: cover property (exec && !aligned && lock_op);
	c_legacy_complement: cover property (
		!prot_cfg_i.protection_scheme_select && prot_cfg_i.protect_complement && prot_locked_o);

	// ----------------------------------------------------------------------
	// origin of every latch rise and lock change
	// ----------------------------------------------------------------------
	// reset is checked on its own, so this one is never disabled
	a_reset_all_locked: assert property (@(posedge clock_i) disable iff (1'b0)
		rst_i |=> &q.lock && !q.write_enable_latch)
		else $error("reset left a block unlocked or latch set");

	a_disable_clears: assert property (
		exec && aligned && rep.opcode == lock_pkg::OP_WRITE_DISABLE |=> !q.write_enable_latch)
		else $error("write disable left latch set");

	a_wel_rise_cause: assert property (
		$rose(q.write_enable_latch) |-> $past(exec && aligned && rep.opcode == lock_pkg::OP_WRITE_ENABLE))
		else $error("latch set without write enable");

	a_lock_set_cause: assert property (
		(q.lock & ~$past(q.lock)) != '0 |-> $past(exec && aligned && q.write_enable_latch &&
		(rep.opcode == lock_pkg::OP_BLOCK_LOCK || rep.opcode == lock_pkg::OP_GLOBAL_LOCK)))
		else $error("block locked without enabled lock command");

	a_lock_clear_cause: assert property (
		(~q.lock & $past(q.lock)) != '0 |-> $past(exec && aligned && q.write_enable_latch &&
		(rep.opcode == lock_pkg::OP_BLOCK_UNLOCK || rep.opcode == lock_pkg::OP_GLOBAL_UNLOCK)))
		else $error("block unlocked without enabled unlock command");

	a_short_frame_hold: assert property (
		exec && !addr_full && (rep.opcode == lock_pkg::OP_BLOCK_LOCK ||
		rep.opcode == lock_pkg::OP_BLOCK_UNLOCK) |=> $stable(q.lock))
		else $error("short block command changed locks");

	a_block_lock_scope: assert property (
		exec && aligned && addr_full && q.write_enable_latch && rep.opcode == lock_pkg::OP_BLOCK_LOCK
		|=> $countones(q.lock ^ $past(q.lock)) <= 1)
		else $error("single lock touched other blocks");

	a_one_exec_frame: assert property (
		exec |=> !exec)
		else $error("frame executed twice");

	// ----------------------------------------------------------------------
	// readback and protection decode
	// ----------------------------------------------------------------------
	a_readback_inert: assert property (
		exec && lock_pkg::is_readback(rep.opcode) |=> $stable(q.lock) && $stable(q.write_enable_latch))
		else $error("readback changed state");

	a_lock_bit_hold: assert property (
		!req_new |=> $stable(q.lock_bit))
		else $error("readback bit moved without request");

	a_legacy_decode: assert property (
		!prot_cfg_i.protection_scheme_select
		|=> prot_locked_o == $past(legacy_hit ^ prot_cfg_i.protect_complement))
		else $error("protection not from legacy bits");

	// ----------------------------------------------------------------------
	// security store
	// ----------------------------------------------------------------------
	a_otp_clears_wel: assert property (
		otp_prog && !exec |=> !q.write_enable_latch)
		else $error("store program left latch set");

	a_otp_needs_wel: assert property (
		otp_prog_i && !q.write_enable_latch |=> $stable(otp.q.mem))
		else $error("store written without latch");

	a_otp_factory_hold: assert property (
		otp_prog_i && otp_addr_i <= lock_pkg::OTP_FACTORY_LAST |=> $stable(otp.q.mem))
		else $error("factory register written");

	a_otp_apart: assert property (
		!otp_prog |=> $stable(otp.q.mem))
		else $error("store changed without program");

	a_lock_apart: assert property (
		otp_prog && !exec |=> $stable(q.lock))
		else $error("store program changed locks");
endmodule

//--- verif/spi_host_model.sv
/*
 * serial host model: drives chip select, serial clock and data in mode 0, samples so.
 * assumes the bench calls frame(), which itself keeps 100 ns of chip select high after each one.
 */
`timescale 1ns/1ps
module spi_host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic so_i,
	input wire logic so_oe_i
);
	// ------------------------------------------------------------
	// idle levels: clock stands low between frames
	// ------------------------------------------------------------
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// ------------------------------------------------------------
	// one frame of n bits, 48 ns clock, reply sampled from bit 33
	// ------------------------------------------------------------
	task automatic frame(input logic [47:0] bits, input int n, output logic [15:0] rx,
		output logic oe);
		rx = 16'h0000;
		oe = 1'b0;
		cs_n_o = 1'b0;
		#24;
		for (int i = 0; i < n; i++) begin
			mosi_o = bits[47-i];
			#24 sclk_o = 1'b1;
			if (i == 32) begin
				oe = so_oe_i;
			end
			if (i >= 32) begin
				rx = {rx[14:0], so_i};
			end
			#24 sclk_o = 1'b0;
		end
		// whole command sent before chip select rises
		#24 cs_n_o = 1'b1;
		mosi_o = ~mosi_o; // released line shows no stale value
		#100;
	endtask
endmodule

//--- verif/spi_flash_block_lock_control_tb.sv
/*
 * self-checking bench of the block lock control: lock commands, readback, protection
 * decode and security store. assumes the host model paces frames by itself.
 */
`timescale 1ns/1ps
module spi_flash_block_lock_control_tb;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic sclk, cs_n, mosi, so, so_oe, prot_locked, write_enable_latch, otp_prog;
	lock_pkg::prot_cfg_t prot_cfg = '0;
	logic [23:0] prot_addr = 24'h000000;
	logic [8:0] otp_addr = 9'h000;
	logic [7:0] otp_wdata = 8'h00;
	logic [7:0] otp_rdata;
	int error_cnt = 0;
	int checks_done = 0;

	// ------------------------------------------------------------
	// clock, host model and block
	// ------------------------------------------------------------
	always #5 clock_i = ~clock_i;

	spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .so_i(so),
		.so_oe_i(so_oe));

	spi_flash_block_lock_control dut (.clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk),
		.cs_n_i(cs_n), .mosi_i(mosi), .so_o(so), .so_oe_o(so_oe), .prot_cfg_i(prot_cfg),
		.prot_addr_i(prot_addr), .prot_locked_o(prot_locked), .write_enable_latch_o(write_enable_latch),
		.otp_addr_i(otp_addr), .otp_wdata_i(otp_wdata), .otp_prog_i(otp_prog),
		.otp_rdata_o(otp_rdata));

	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic send(input logic [7:0] op, input logic [23:0] a, input int n);
		logic [15:0] rx;
		logic oe;
		host.frame({op, a, 16'h0000}, n, rx, oe);
	endtask

	// two readback bytes; bits 7:1 driven 0, bit 0 the lock bit
	task automatic rd_lock(input logic [7:0] op, input logic [23:0] a, input logic lk);
		logic [15:0] rx;
		logic oe;
		host.frame({op, a, 16'h0000}, 48, rx, oe);
		chk("readback enable", 16'h0001, {15'h0000, oe});
		chk("readback bytes", {7'h00, lk, 7'h00, lk}, rx);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk("latch after reset", 16'h0000, {15'h0000, write_enable_latch});
		rd_lock(8'h3C, 24'h000000, 1'b1);
		rd_lock(8'h3D, 24'h1FF000, 1'b1);
	endtask

	task automatic t_unlock();
		send(8'h06, 24'h000000, 8);
		send(8'h04, 24'h000000, 8);
		chk("latch after disable", 16'h0000, {15'h0000, write_enable_latch});
		send(8'h39, 24'h001234, 32);
		chk("latch stays clear", 16'h0000, {15'h0000, write_enable_latch});
		rd_lock(8'h3C, 24'h001000, 1'b1);
		send(8'h06, 24'h000000, 8);
		chk("latch set", 16'h0001, {15'h0000, write_enable_latch});
		send(8'h39, 24'h001234, 32);
		chk("latch cleared", 16'h0000, {15'h0000, write_enable_latch});
		rd_lock(8'h3D, 24'h001FFF, 1'b0);
		rd_lock(8'h3C, 24'h002000, 1'b1);
	endtask

	task automatic t_global();
		send(8'h06, 24'h000000, 8);
		send(8'h39, 24'h005000, 31);
		chk("latch after abort", 16'h0001, {15'h0000, write_enable_latch});
		rd_lock(8'h3C, 24'h005000, 1'b1);
		send(8'h98, 24'h000000, 8);
		chk("latch after global", 16'h0000, {15'h0000, write_enable_latch});
		rd_lock(8'h3C, 24'h1FF000, 1'b0);
		send(8'h06, 24'h000000, 8);
		send(8'h36, 24'h005ABC, 32);
		rd_lock(8'h3D, 24'h005000, 1'b1);
		rd_lock(8'h3D, 24'h006000, 1'b0);
		send(8'h06, 24'h000000, 8);
		send(8'h7E, 24'h000000, 8);
		rd_lock(8'h3C, 24'h006000, 1'b1);
		rd_lock(8'h3C, 24'h1FF000, 1'b1);
	endtask

	task automatic t_prot();
		send(8'h06, 24'h000000, 8);
		send(8'h39, 24'h003000, 32);
		step(1);
		prot_cfg.protection_scheme_select = 1'b1;
		prot_addr = 24'h003800;
		step(2);
		chk("block scheme open", 16'h0000, {15'h0000, prot_locked});
		prot_addr = 24'h004000;
		step(2);
		chk("block scheme locked", 16'h0001, {15'h0000, prot_locked});
		prot_cfg = '0;
		step(2);
		chk("legacy none", 16'h0000, {15'h0000, prot_locked});
		prot_cfg.block_protect_bits = 3'h1;
		prot_cfg.top_bottom_select = 1'b1;
		step(2);
		chk("legacy bottom", 16'h0001, {15'h0000, prot_locked});
		prot_addr = 24'h1F0000;
		step(2);
		chk("legacy outside", 16'h0000, {15'h0000, prot_locked});
		prot_cfg.protect_complement = 1'b1;
		step(2);
		chk("legacy complement", 16'h0001, {15'h0000, prot_locked});
		prot_cfg = '{1'b0, 1'b0, 1'b1, 1'b0, 3'h1};
		prot_addr = 24'h1FF800;
		step(2);
		chk("legacy top sector", 16'h0001, {15'h0000, prot_locked});
		prot_addr = 24'h1FE000;
		step(2);
		chk("legacy below top", 16'h0000, {15'h0000, prot_locked});
	endtask

	task automatic otp_pulse(input logic [8:0] a, input logic [7:0] d);
		otp_addr = a;
		otp_wdata = d;
		otp_prog = 1'b1;
		step(1);
		otp_prog = 1'b0;
		step(2);
	endtask

	task automatic t_otp();
		otp_pulse(9'h0C8, 8'h5A);
		chk("otp without latch", 16'h00FF, {8'h00, otp_rdata});
		send(8'h06, 24'h000000, 8);
		step(1);
		otp_pulse(9'h0C8, 8'h5A);
		chk("otp user byte", 16'h005A, {8'h00, otp_rdata});
		chk("latch after otp", 16'h0000, {15'h0000, write_enable_latch});
		send(8'h06, 24'h000000, 8);
		step(1);
		otp_pulse(9'h00A, 8'h00);
		chk("otp factory byte", 16'h00FF, {8'h00, otp_rdata});
		rd_lock(8'h3C, 24'h004000, 1'b1);
		rd_lock(8'h3C, 24'h003000, 1'b0);
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		otp_prog = 1'b0;
		step(3);
		rst_i = 1'b0;
		step(2);
		t_reset();
		t_unlock();
		t_global();
		t_prot();
		t_otp();
		close_out();
	end

	initial begin
		#400000;
		error_cnt++;
		close_out();
	end
endmodule
